// File: rtl/camd_cfg.svh
// constants of the addressing-mode decoder: opcode classes, prebytes, ranges
// assumes inclusion by camd_pkg users and by the decoder module
`ifndef CAMD_CFG_SVH
`define CAMD_CFG_SVH
// ==========================================================
// prebyte codes
`define CAMD_PRE_Y      8'h90
`define CAMD_PRE_IND    8'h92
`define CAMD_PRE_INDY   8'h91
// ==========================================================
// opcode classes, taken from the opcode's upper nibble
`define CAMD_CLS_INH    4'h0
`define CAMD_CLS_IMM    4'h1
`define CAMD_CLS_DIRS   4'h2
`define CAMD_CLS_DIRL   4'h3
`define CAMD_CLS_IDX0   4'h4
`define CAMD_CLS_IDXS   4'h5
`define CAMD_CLS_IDXL   4'h6
`define CAMD_CLS_REL    4'h7
`define CAMD_CLS_RELATIVE_SUBROUTINE_CALL  4'h8
// opcode bit that marks an operation with short forms only
`define CAMD_SHORT_ONLY 3
// ==========================================================
// address figures and lengths
`define CAMD_PAGE0      8'h00
`define CAMD_INC16      16'h0001
`define CAMD_IDXS_TOP   16'h01fe
`define CAMD_LEN_ONE    3'h1
`define CAMD_LEN_IMM    3'h2
`define CAMD_LEN_LONG   3'h3
`define CAMD_LEN_MAX    3'h4
`define CAMD_EXT_ONE    2'h1
`define CAMD_EXT_TWO    2'h2
`endif

// File: rtl/camd_pkg.sv
// types of the addressing-mode decoder: states, modes, prefixes, decode record
// assumes camd_cfg.svh supplies the numeric constants
`default_nettype none
package camd_pkg;
	typedef enum logic [5:0] {
		S_OPC  = 6'h01,
		S_OP1  = 6'h02,
		S_OP2  = 6'h04,
		S_PTRH = 6'h08,
		S_PTRL = 6'h10,
		S_EXE  = 6'h20
	} camd_state_t;

	typedef enum logic [3:0] {
		M_INH  = 4'h0,
		M_IMM  = 4'h1,
		M_DIRS = 4'h2,
		M_DIRL = 4'h3,
		M_IDX0 = 4'h4,
		M_IDXS = 4'h5,
		M_IDXL = 4'h6,
		M_INDS = 4'h7,
		M_INDL = 4'h8,
		M_IIXS = 4'h9,
		M_IIXL = 4'ha,
		M_RELD = 4'hb,
		M_RELI = 4'hc
	} camd_mode_t;

	typedef enum logic [1:0] {
		P_NONE = 2'h0,
		P_Y    = 2'h1,
		P_IND  = 2'h2,
		P_INDY = 2'h3
	} camd_pfx_t;

	typedef struct packed {
		camd_mode_t  mode;
		logic        use_y;
		logic        unauth;
		logic [2:0]  len;
		logic [15:0] ea;
		logic [7:0]  imm;
	} camd_dec_t;

	typedef struct packed {
		logic       legal;
		camd_mode_t mode;
		logic       use_y;
		logic       unauth;
		logic [1:0] ext;
		logic       wptr;
	} camd_cls_t;

	typedef struct packed {
		camd_state_t state;
		camd_pfx_t   pfx;
		logic [2:0]  len;
		camd_mode_t  mode;
		logic        use_y;
		logic        unauth;
		logic        wptr;
		logic [1:0]  ext;
		logic [7:0]  b1;
		logic [7:0]  b2;
		logic [7:0]  phi;
		logic [7:0]  plo;
		logic [15:0] npc;
		logic        mem_rd;
		logic [15:0] mem_addr;
		logic        dvld;
		logic        ill;
		camd_dec_t   dec;
	} camd_st_t;
endpackage : camd_pkg
`default_nettype wire

// File: rtl/camd_dec.sv
// instruction decode and effective-address unit of the 8-bit core
// assumes fetch, index registers and data memory run on CLK_SYS
// Operation
// - inherent instruction is one opcode byte
// - immediate is opcode plus one operand byte
// - short direct takes one byte, page zero
// - long direct takes a two-byte address word
// - indexed address is unsigned index plus offset
// - indexed without offset uses index alone
// - short indexed adds offset byte, up to 1fe
// - long indexed adds a word offset
// - indirect fetches byte or word pointer
// - indirect indexed adds index to fetched pointer
// - relative adds sign-extended byte to PC
// - relative offset inline or fetched from memory
// - relative base is the following instruction
// - long forms only for load/compare/logic/arith
// - instructions are one to four bytes
// - prebyte, opcode, then zero to two bytes
// - prefix_second_index turns X forms into Y
// - prefix_indirect turns direct and offset-indexed forms into indirect
// - prefix_indirect_second_index gives Y indirect indexed
// - undefined opcode byte raises a reset
// - unauthorised prebyte pairing raises no reset
`timescale 1ns/1ps
`default_nettype none
`include "camd_cfg.svh"

module camd_dec (
	input  wire logic              CLK_SYS,    // core clock, 20 MHz
	input  wire logic              NRST,       // system reset
	input  wire logic              BYTE_VALID, // fetched byte offered
	input  wire logic [7:0]        BYTE_DATA,  // fetched byte
	input  wire logic [15:0]       BYTE_ADDR,  // address of fetched byte
	output logic                   BYTE_READY, // decoder takes byte
	input  wire logic [7:0]        IDX_X,      // first index register
	input  wire logic [7:0]        IDX_Y,      // second index register
	output logic                   MEM_RD,     // pointer read request
	output logic [15:0]            MEM_ADDR,   // pointer read address
	input  wire logic              MEM_ACK,    // pointer read done
	input  wire logic [7:0]        MEM_RDATA,  // pointer read data
	output logic                   DEC_VALID,  // decode result pulse
	output camd_pkg::camd_dec_t    DEC,        // decode result
	output logic                   ILL_RST     // illegal opcode reset pulse
);

	// ==========================================================
	// opcode classification
	function automatic camd_pkg::camd_cls_t classify(
		input logic [7:0]          opc,
		input camd_pkg::camd_pfx_t pf
	);
		camd_pkg::camd_cls_t c;
		logic                lng_ok;
		logic                ind;
		c       = '0;
		lng_ok  = !opc[`CAMD_SHORT_ONLY];
		ind     = (pf == camd_pkg::P_IND) || (pf == camd_pkg::P_INDY);
		c.legal = 1'b1;
		c.use_y = (pf == camd_pkg::P_Y);
		case (opc[7:4])
			`CAMD_CLS_INH: begin
				c.mode   = camd_pkg::M_INH;
				c.unauth = ind;
			end
			`CAMD_CLS_IMM: begin
				c.legal  = lng_ok;
				c.mode   = camd_pkg::M_IMM;
				c.ext    = `CAMD_EXT_ONE;
				c.unauth = ind;
			end
			`CAMD_CLS_DIRS: begin
				c.ext    = `CAMD_EXT_ONE;
				c.mode   = (pf == camd_pkg::P_IND) ? camd_pkg::M_INDS
					: camd_pkg::M_DIRS;
				c.unauth = (pf == camd_pkg::P_INDY);
			end
			`CAMD_CLS_DIRL: begin
				c.legal  = lng_ok;
				c.unauth = (pf == camd_pkg::P_INDY);
				if (pf == camd_pkg::P_IND) begin
					c.mode = camd_pkg::M_INDL;
					c.ext  = `CAMD_EXT_ONE;
					c.wptr = 1'b1;
				end else begin
					c.mode = camd_pkg::M_DIRL;
					c.ext  = `CAMD_EXT_TWO;
				end
			end
			`CAMD_CLS_IDX0: begin
				c.mode   = camd_pkg::M_IDX0;
				c.unauth = ind;
			end
			`CAMD_CLS_IDXS: begin
				c.ext   = `CAMD_EXT_ONE;
				c.mode  = ind ? camd_pkg::M_IIXS : camd_pkg::M_IDXS;
				c.use_y = (pf == camd_pkg::P_Y) || (pf == camd_pkg::P_INDY);
			end
			`CAMD_CLS_IDXL: begin
				c.legal = lng_ok;
				c.use_y = (pf == camd_pkg::P_Y) || (pf == camd_pkg::P_INDY);
				if (ind) begin
					c.mode = camd_pkg::M_IIXL;
					c.ext  = `CAMD_EXT_ONE;
					c.wptr = 1'b1;
				end else begin
					c.mode = camd_pkg::M_IDXL;
					c.ext  = `CAMD_EXT_TWO;
				end
			end
			`CAMD_CLS_REL, `CAMD_CLS_RELATIVE_SUBROUTINE_CALL: begin
				c.ext    = `CAMD_EXT_ONE;
				c.mode   = (pf == camd_pkg::P_IND) ? camd_pkg::M_RELI
					: camd_pkg::M_RELD;
				c.use_y  = 1'b0;
				c.unauth = (pf == camd_pkg::P_Y) || (pf == camd_pkg::P_INDY);
			end
			default: begin
				c.legal = 1'b0;
			end
		endcase
		return c;
	endfunction : classify

	// ==========================================================
	// state and next state
	camd_pkg::camd_st_t  st_ff;
	camd_pkg::camd_st_t  nxt_st;
	camd_pkg::camd_cls_t cls;
	camd_pkg::camd_pfx_t pfx_in;
	logic                is_pre;
	logic                take;
	logic                ill_now;
	logic                need_ptr;
	logic [15:0]         idx16;
	logic [15:0]         ptrw;
	logic [7:0]          off8;
	logic [15:0]         ea;

	always_comb begin
		BYTE_READY = (st_ff.state == camd_pkg::S_OPC)
			|| (st_ff.state == camd_pkg::S_OP1)
			|| (st_ff.state == camd_pkg::S_OP2);
		take   = BYTE_VALID && BYTE_READY;
		is_pre = 1'b1;
		pfx_in = camd_pkg::P_NONE;
		if (BYTE_DATA == `CAMD_PRE_Y) begin
			pfx_in = camd_pkg::P_Y;
		end else if (BYTE_DATA == `CAMD_PRE_IND) begin
			pfx_in = camd_pkg::P_IND;
		end else if (BYTE_DATA == `CAMD_PRE_INDY) begin
			pfx_in = camd_pkg::P_INDY;
		end else begin
			is_pre = 1'b0;
		end
		cls     = classify(BYTE_DATA, st_ff.pfx);
		ill_now = take && (st_ff.state == camd_pkg::S_OPC) && !is_pre
			&& !cls.legal;
		need_ptr = (st_ff.mode == camd_pkg::M_INDS) || (st_ff.mode == camd_pkg::M_INDL)
			|| (st_ff.mode == camd_pkg::M_IIXS) || (st_ff.mode == camd_pkg::M_IIXL)
			|| (st_ff.mode == camd_pkg::M_RELI);
	end

	// effective address from the gathered bytes
	always_comb begin
		idx16 = {`CAMD_PAGE0, st_ff.use_y ? IDX_Y : IDX_X};
		ptrw  = {st_ff.phi, st_ff.plo};
		off8  = (st_ff.mode == camd_pkg::M_RELI) ? st_ff.plo : st_ff.b1;
		case (st_ff.mode)
			camd_pkg::M_DIRS: ea = {`CAMD_PAGE0, st_ff.b1};
			camd_pkg::M_DIRL: ea = {st_ff.b1, st_ff.b2};
			camd_pkg::M_IDX0: ea = idx16;
			camd_pkg::M_IDXS: ea = idx16 + {`CAMD_PAGE0, st_ff.b1};
			camd_pkg::M_IDXL: ea = {st_ff.b1, st_ff.b2} + idx16;
			camd_pkg::M_INDS: ea = {`CAMD_PAGE0, st_ff.plo};
			camd_pkg::M_INDL: ea = ptrw;
			camd_pkg::M_IIXS: ea = idx16 + {`CAMD_PAGE0, st_ff.plo};
			camd_pkg::M_IIXL: ea = ptrw + idx16;
			camd_pkg::M_RELD, camd_pkg::M_RELI:
				ea = st_ff.npc + {{8{off8[7]}}, off8};
			default: ea = '0;
		endcase
	end

	// ==========================================================
	// sequencer
	always_comb begin
		nxt_st      = st_ff;
		nxt_st.dvld = 1'b0;
		nxt_st.ill  = 1'b0;
		case (st_ff.state)
			camd_pkg::S_OPC: begin
				if (take) begin
					nxt_st.npc = BYTE_ADDR + `CAMD_INC16;
					nxt_st.len = st_ff.len + `CAMD_LEN_ONE;
					if (is_pre && st_ff.pfx == camd_pkg::P_NONE) begin
						nxt_st.pfx = pfx_in;
					end else if (is_pre) begin
						// second prebyte: both codes are defined, so no reset
						nxt_st.mode   = camd_pkg::M_INH;
						nxt_st.unauth = 1'b1;
						nxt_st.use_y  = 1'b0;
						nxt_st.state  = camd_pkg::S_EXE;
					end else if (!cls.legal) begin
						nxt_st.ill = 1'b1;
						nxt_st.pfx = camd_pkg::P_NONE;
						nxt_st.len = '0;
					end else begin
						nxt_st.mode   = cls.mode;
						nxt_st.use_y  = cls.use_y;
						nxt_st.unauth = cls.unauth;
						nxt_st.ext    = cls.ext;
						nxt_st.wptr   = cls.wptr;
						nxt_st.state  = (cls.ext == '0) ? camd_pkg::S_EXE
							: camd_pkg::S_OP1;
					end
				end
			end
			camd_pkg::S_OP1: begin
				if (take) begin
					nxt_st.b1  = BYTE_DATA;
					nxt_st.npc = BYTE_ADDR + `CAMD_INC16;
					nxt_st.len = st_ff.len + `CAMD_LEN_ONE;
					if (st_ff.ext == `CAMD_EXT_TWO) begin
						nxt_st.state = camd_pkg::S_OP2;
					end else if (need_ptr) begin
						nxt_st.mem_rd   = 1'b1;
						nxt_st.mem_addr = {`CAMD_PAGE0, BYTE_DATA};
						nxt_st.state    = st_ff.wptr ? camd_pkg::S_PTRH
							: camd_pkg::S_PTRL;
					end else begin
						nxt_st.state = camd_pkg::S_EXE;
					end
				end
			end
			camd_pkg::S_OP2: begin
				if (take) begin
					nxt_st.b2    = BYTE_DATA;
					nxt_st.npc   = BYTE_ADDR + `CAMD_INC16;
					nxt_st.len   = st_ff.len + `CAMD_LEN_ONE;
					nxt_st.state = camd_pkg::S_EXE;
				end
			end
			camd_pkg::S_PTRH: begin
				if (MEM_ACK) begin
					nxt_st.phi      = MEM_RDATA;
					nxt_st.mem_addr = st_ff.mem_addr + `CAMD_INC16;
					nxt_st.state    = camd_pkg::S_PTRL;
				end
			end
			camd_pkg::S_PTRL: begin
				if (MEM_ACK) begin
					nxt_st.plo    = MEM_RDATA;
					nxt_st.mem_rd = 1'b0;
					nxt_st.state  = camd_pkg::S_EXE;
				end
			end
			camd_pkg::S_EXE: begin
				nxt_st.dvld       = 1'b1;
				nxt_st.dec.mode   = st_ff.mode;
				nxt_st.dec.use_y  = st_ff.use_y;
				nxt_st.dec.unauth = st_ff.unauth;
				nxt_st.dec.len    = st_ff.len;
				nxt_st.dec.ea     = ea;
				nxt_st.dec.imm    = (st_ff.mode == camd_pkg::M_IMM) ? st_ff.b1 : '0;
				nxt_st.pfx        = camd_pkg::P_NONE;
				nxt_st.len        = '0;
				nxt_st.unauth     = 1'b0;
				nxt_st.state      = camd_pkg::S_OPC;
			end
			default: begin
				nxt_st.state = camd_pkg::S_OPC;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			st_ff       <= '0;
			st_ff.state <= camd_pkg::S_OPC;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign MEM_RD    = st_ff.mem_rd;
	assign MEM_ADDR  = st_ff.mem_addr;
	assign DEC_VALID = st_ff.dvld;
	assign DEC       = st_ff.dec;
	assign ILL_RST   = st_ff.ill;

	// ==========================================================
	// checks
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!NRST);

	a_ill_cause: assert property (
		ill_now |=> ILL_RST && !DEC_VALID
	) else $error("illegal byte did not raise reset");

	a_unauth_quiet: assert property (
		DEC_VALID && DEC.unauth |-> !ILL_RST && !$past(ILL_RST)
	) else $error("unauthorised pairing raised reset");

	a_inh_length: assert property (
		DEC_VALID && DEC.mode == camd_pkg::M_INH && !DEC.unauth
			|-> DEC.len == `CAMD_LEN_ONE + 3'(DEC.use_y)
	) else $error("inherent length wrong");

	a_imm_length: assert property (
		DEC_VALID && DEC.mode == camd_pkg::M_IMM
			|-> DEC.len == `CAMD_LEN_IMM + 3'(DEC.use_y || DEC.unauth)
	) else $error("immediate length wrong");

	a_dirl_length: assert property (
		DEC_VALID && DEC.mode == camd_pkg::M_DIRL
			|-> DEC.len == `CAMD_LEN_LONG + 3'(DEC.use_y || DEC.unauth)
	) else $error("long direct length wrong");

	a_len_range: assert property (
		DEC_VALID |-> DEC.len >= `CAMD_LEN_ONE && DEC.len <= `CAMD_LEN_MAX
	) else $error("instruction length out of range");

	a_page_zero: assert property (
		DEC_VALID && (DEC.mode == camd_pkg::M_DIRS || DEC.mode == camd_pkg::M_INDS)
			|-> DEC.ea[15:8] == `CAMD_PAGE0
	) else $error("short address left page zero");

	a_idx0_addr: assert property (
		DEC_VALID && DEC.mode == camd_pkg::M_IDX0
			|-> DEC.ea == {`CAMD_PAGE0, DEC.use_y ? IDX_Y : IDX_X} || $changed(IDX_X)
			|| $changed(IDX_Y)
	) else $error("no-offset index address wrong");

	a_idxs_top: assert property (
		DEC_VALID && (DEC.mode == camd_pkg::M_IDXS || DEC.mode == camd_pkg::M_IIXS)
			|-> DEC.ea <= `CAMD_IDXS_TOP
	) else $error("short indexed address above range");

	a_ptr_hold: assert property (
		MEM_RD && !MEM_ACK |=> MEM_RD && $stable(MEM_ADDR)
	) else $error("pointer request dropped before answer");

	a_exe_result: assert property (
		st_ff.state == camd_pkg::S_EXE |=> DEC_VALID ##1 !DEC_VALID
	) else $error("decode result not one cycle after gathering");

endmodule : camd_dec

`default_nettype wire

// File: tb/tb_cpu_addressing_mode_decoder.sv
// self-checking bench of the addressing-mode decoder camd_dec
// assumes camd_pkg is compiled first; a memory responder answers pointer reads
`timescale 1ns/1ps
`default_nettype none

module tb_cpu_addressing_mode_decoder;
	typedef struct {
		camd_pkg::camd_dec_t d;
		logic                ill;
	} camd_exp_t;

	logic                CLK_SYS, NRST, BYTE_VALID, BYTE_READY, MEM_RD, MEM_ACK;
	logic                DEC_VALID, ILL_RST;
	logic [7:0]          BYTE_DATA, IDX_X, IDX_Y, MEM_RDATA, pre, opc;
	logic [15:0]         BYTE_ADDR, MEM_ADDR, pc;
	logic [1:0]          wt;
	camd_pkg::camd_dec_t DEC;
	camd_exp_t           q[$];
	int                  mismatches, n_checks, cyc;

	camd_dec DUT (.CLK_SYS(CLK_SYS), .NRST(NRST), .BYTE_VALID(BYTE_VALID),
		.BYTE_DATA(BYTE_DATA), .BYTE_ADDR(BYTE_ADDR), .BYTE_READY(BYTE_READY),
		.IDX_X(IDX_X), .IDX_Y(IDX_Y), .MEM_RD(MEM_RD), .MEM_ADDR(MEM_ADDR),
		.MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA), .DEC_VALID(DEC_VALID), .DEC(DEC),
		.ILL_RST(ILL_RST));

	always #25 CLK_SYS = ~CLK_SYS;

	// ==========================================================
	// helpers
	function automatic logic [7:0] mem(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h3c;
	endfunction : mem

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : end_sim

	// request held until the edge that samples ready high
	task automatic send(input logic [7:0] b);
		int n;
		BYTE_VALID <= 1'b1;
		BYTE_DATA  <= b;
		BYTE_ADDR  <= pc;
		n = 0;
		do begin
			@(posedge CLK_SYS);
			n++;
		end while (BYTE_READY !== 1'b1 && n < 100);
		pc = pc + 16'h0001;
	endtask : send

	task automatic instr(input logic [7:0] p, input logic [7:0] o, input logic [7:0] b1,
		input logic [7:0] b2);
		camd_exp_t   e;
		logic [3:0]  c;
		logic [7:0]  ix;
		logic [15:0] ptr, wp;
		logic        ind;
		int          nb;
		c = o[7:4];
		ind = (p == 8'h92 || p == 8'h91);
		ix = (p == 8'h90 || p == 8'h91) ? IDX_Y : IDX_X;
		nb = (c == 4'h0 || c == 4'h4) ? 0 : ((c == 4'h3 || c == 4'h6) && !ind) ? 2 : 1;
		ptr = {8'h00, b1};
		wp = {mem(ptr), mem(ptr + 16'h0001)};
		e.ill = 1'b0;
		e.d = '0;
		e.d.use_y = (p == 8'h90 || p == 8'h91);
		e.d.len = 3'(nb + 1 + int'(p != 8'h00));
		case (c)
			4'h0: e.d.mode = camd_pkg::M_INH;
			4'h1: begin
				e.d.mode = camd_pkg::M_IMM;
				e.d.imm = b1;
			end
			4'h2: begin
				e.d.mode = ind ? camd_pkg::M_INDS : camd_pkg::M_DIRS;
				e.d.ea = ind ? {8'h00, mem(ptr)} : ptr;
			end
			4'h3: begin
				e.d.mode = ind ? camd_pkg::M_INDL : camd_pkg::M_DIRL;
				e.d.ea = ind ? wp : {b1, b2};
			end
			4'h4: begin
				e.d.mode = camd_pkg::M_IDX0;
				e.d.ea = {8'h00, ix};
			end
			4'h5: begin
				e.d.mode = ind ? camd_pkg::M_IIXS : camd_pkg::M_IDXS;
				e.d.ea = 16'(ix) + (ind ? 16'(mem(ptr)) : ptr);
			end
			4'h6: begin
				e.d.mode = ind ? camd_pkg::M_IIXL : camd_pkg::M_IDXL;
				e.d.ea = 16'(ix) + (ind ? wp : {b1, b2});
			end
			default: begin
				e.d.mode = ind ? camd_pkg::M_RELI : camd_pkg::M_RELD;
				wp[7:0] = ind ? mem(ptr) : b1;
				e.d.ea = pc + 16'(e.d.len) + {{8{wp[7]}}, wp[7:0]};
			end
		endcase
		q.push_back(e);
		if (p != 8'h00) send(p);
		send(o);
		if (nb > 0) send(b1);
		if (nb > 1) send(b2);
	endtask : instr

	task automatic bad(input logic [7:0] b);
		camd_exp_t e;
		e.ill = 1'b1;
		e.d = '0;
		q.push_back(e);
		send(b);
	endtask : bad

	task automatic idle(input string name);
		int n;
		BYTE_VALID <= 1'b0;
		n = 0;
		while (q.size() != 0 && n < 200) begin
			@(posedge CLK_SYS);
			n++;
		end
		check(16'(q.size()), 16'h0000, "missing result");
		repeat (3) @(posedge CLK_SYS);
		IDX_X <= 8'($urandom);
		IDX_Y <= 8'($urandom);
		@(posedge CLK_SYS);
		$display("test %s done", name);
	endtask : idle

	// ==========================================================
	// pointer memory, answers after 0 to 3 cycles
	always @(posedge CLK_SYS) begin
		if (MEM_RD === 1'b1 && MEM_ACK !== 1'b1 && wt == 2'h0) begin
			MEM_ACK   <= 1'b1;
			MEM_RDATA <= mem(MEM_ADDR);
			wt        <= 2'($urandom);
		end else begin
			MEM_ACK   <= 1'b0;
			MEM_RDATA <= ~MEM_RDATA;
			if (MEM_RD === 1'b1 && wt != 2'h0) wt <= wt - 2'h1;
		end
	end

	// result watcher
	always @(posedge CLK_SYS) begin
		camd_exp_t e;
		if (NRST === 1'b1 && (DEC_VALID !== 1'b0 || ILL_RST !== 1'b0)) begin
			if (q.size() == 0) begin
				check(16'h0001, 16'h0000, "unexpected result");
			end else begin
				e = q.pop_front();
				check(16'(ILL_RST), 16'(e.ill), "illegal reset");
				if (!e.ill) begin
					check(16'(DEC.mode), 16'(e.d.mode), "mode");
					check(16'(DEC.use_y), 16'(e.d.use_y), "index");
					check(16'(DEC.unauth), 16'(e.d.unauth), "pairing");
					check(16'(DEC.len), 16'(e.d.len), "length");
					check(DEC.ea, e.d.ea, "address");
					if (e.d.mode == camd_pkg::M_IMM) check(16'(DEC.imm), 16'(e.d.imm), "imm");
				end
			end
		end
	end

	always @(posedge CLK_SYS) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			end_sim;
		end
	end

	// ==========================================================
	// main sequence
	initial begin
		CLK_SYS = 1'b0;
		NRST = 1'b0;
		BYTE_VALID = 1'b0;
		BYTE_DATA = 8'h00;
		BYTE_ADDR = 16'h0000;
		IDX_X = 8'h00;
		IDX_Y = 8'h00;
		MEM_ACK = 1'b0;
		MEM_RDATA = 8'h00;
		wt = 2'h0;
		pc = 16'h0100;
		void'($urandom(7));
		repeat (5) @(posedge CLK_SYS);
		NRST <= 1'b1;
		idle("reset");
		IDX_X <= 8'hff;
		IDX_Y <= 8'hff;
		@(posedge CLK_SYS);
		instr(8'h00, 8'h50, 8'hff, 8'h00);
		instr(8'h91, 8'h50, 8'hff, 8'h00);
		instr(8'h92, 8'h30, 8'hff, 8'h00);
		instr(8'h92, 8'h60, 8'hfe, 8'h00);
		instr(8'h00, 8'h70, 8'h80, 8'h00);
		instr(8'h00, 8'h8b, 8'h7f, 8'h00);
		idle("boundary");
		for (int i = 0; i < 160; i++) begin
			case ($urandom % 4)
				0: pre = 8'h00;
				1: pre = 8'h90;
				2: pre = 8'h92;
				default: pre = 8'h91;
			endcase
			case (pre)
				8'h00: opc[7:4] = 4'($urandom % 9);
				8'h90: opc[7:4] = 4'($urandom % 7);
				8'h92: opc[7:4] = 4'({4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8} >> (4 * ($urandom % 6)));
				default: opc[7:4] = 4'(5 + $urandom % 2);
			endcase
			opc[3:0] = 4'($urandom);
			if (opc[7:4] == 4'h1 || opc[7:4] == 4'h3 || opc[7:4] == 4'h6) opc[3] = 1'b0;
			instr(pre, opc, 8'($urandom), 8'($urandom));
			if (i % 16 == 15) idle("random");
		end
		idle("random");
		for (int k = 0; k < 6; k++) begin
			bad(8'({8'h18, 8'h38, 8'h6c, 8'h9f, 8'ha0, 8'hf3} >> (8 * (5 - k))));
		end
		send(8'h92);
		bad(8'hb0);
		instr(8'h00, 8'h20, 8'h44, 8'h00);
		q.push_back('{d: '{mode: camd_pkg::M_INH, use_y: 1'b0, unauth: 1'b1, len: 3'h2,
			ea: 16'h0000, imm: 8'h00}, ill: 1'b0});
		send(8'h92);
		send(8'h90);
		q.push_back('{d: '{mode: camd_pkg::M_INH, use_y: 1'b0, unauth: 1'b1, len: 3'h2,
			ea: 16'h0000, imm: 8'h00}, ill: 1'b0});
		send(8'h92);
		send(8'h01);
		q.push_back('{d: '{mode: camd_pkg::M_DIRS, use_y: 1'b0, unauth: 1'b1, len: 3'h3,
			ea: 16'h0055, imm: 8'h00}, ill: 1'b0});
		send(8'h91);
		send(8'h20);
		send(8'h55);
		idle("illegal");
		send(8'h30);
		send(8'h12);
		NRST <= 1'b0;
		@(posedge CLK_SYS);
		check(16'({BYTE_READY, MEM_RD, DEC_VALID, ILL_RST}), 16'h0008, "reset outputs");
		BYTE_VALID <= 1'b0;
		@(posedge CLK_SYS);
		NRST <= 1'b1;
		instr(8'h00, 8'h01, 8'h00, 8'h00);
		idle("mid reset");
		end_sim;
	end
endmodule : tb_cpu_addressing_mode_decoder

`default_nettype wire
